// [rtl/sar_dev.sv]
// Purpose: converter end: conversion timing, hold, result readout
// Assumes: link pins arrive from another party, synchronised here
// Notes: analog input is modelled as a digital word
//   a start while converting aborts and clears the result
//   tick phase makes a conversion one cycle shorter at most
//
// Behaviour
// R1: conversion timed by internal oscillator enable
// R2: conversion ends within fixed 650 ns period
// R3: input frozen at conversion start
// R4: inputs disconnected while converting
// R5: host leaves 320 ns acquisition gap
// R6: host gives one strobe per read
// R7: byte select low gives full word
// R8: host reads on busy falling edge
// R9: start pulse low 20 ns, select low
// R10: busy high from start until done
// R11: bus driven only with select and strobe low
// R12: byte high: low byte up, ones below
// R13: host reads only after busy falls
`timescale 1ns/1ps
`default_nettype none
module sar_dev (
    input wire logic ref_clk,
    input wire logic reset,
    sar_link_if.dev link,
    input wire logic [sar_pkg::RESULT_W-1:0] analog_in,
    output logic tracking,
    output logic conv_done
);
    import sar_pkg::*;

    // ******************************
    // decode helpers
    // ******************************
    // falling pin level seen between two synced samples
    function automatic logic pin_fell(
        input logic prev,
        input logic cur
    );
        return prev & ~cur;
    endfunction : pin_fell

    // ******************************
    // readout lane mapping
    // ******************************
    function automatic logic [15:0] fold_word(
        input logic [15:0] word,
        input logic fold
    );
        if (fold) begin
            // folded bus: low byte on upper lanes, fill below
            return {word[7:0], BYTE_FILL}; // R12
        end else begin
            // tied-low select never folds
            return word; // R7
        end
    endfunction : fold_word

    // ******************************
    // state
    // ******************************
    typedef struct packed {
        sar_dev_state_e st;
        logic [1:0] conv_s;
        logic [1:0] cs_s;
        logic [1:0] rd_s;
        logic [1:0] byte_s;
        logic conv_prev;
        logic [7:0] osc_cnt;
        logic [7:0] tick_cnt;
        logic [15:0] hold;
        logic [15:0] result;
        logic busy;
        logic [15:0] bus;
        logic oe;
        logic track;
        logic done;
    } sar_dev_s;

    sar_dev_s st_reg;
    sar_dev_s st_next;

    logic conv_fall;
    logic sel_low;
    logic osc_tick;
    logic last_tick;

    // ******************************
    // combinational next state
    // ******************************
    always_comb begin
        st_next = st_reg;
        st_next.done = 1'b0;

        // ******************************
        // pin synchronisers
        // ******************************
        // pins come from the host's domain: two flops before use
        st_next.conv_s = {st_reg.conv_s[0], link.conversion_start_n};
        st_next.cs_s = {st_reg.cs_s[0], link.cs_n};
        st_next.rd_s = {st_reg.rd_s[0], link.rd_n};
        st_next.byte_s = {st_reg.byte_s[0], link.byte_sel};
        st_next.conv_prev = st_reg.conv_s[1];

        // ******************************
        // start and select decode
        // ******************************
        conv_fall = pin_fell(st_reg.conv_prev, st_reg.conv_s[1]);
        sel_low = ~st_reg.cs_s[1];

        // ******************************
        // internal oscillator
        // ******************************
        // free running, no host clock involved
        osc_tick = (st_reg.osc_cnt == OSC_DIV - 8'h01); // R1
        if (osc_tick) begin
            st_next.osc_cnt = 8'h00;
        end else begin
            st_next.osc_cnt = st_reg.osc_cnt + 8'h01;
        end

        // tick phase at entry shortens a conversion by one cycle at most
        last_tick = osc_tick && (st_reg.tick_cnt == CONV_TICKS - 8'h01);

        // ******************************
        // conversion control
        // ******************************
        case (st_reg.st)
            SAR_DEV_TRACK: begin
                // start accepted only while selected
                if (conv_fall && sel_low) begin
                    st_next.hold = analog_in; // R3
                    st_next.busy = 1'b1; // R10
                    st_next.track = 1'b0; // R4
                    st_next.tick_cnt = 8'h00;
                    st_next.st = SAR_DEV_CONV;
                end
            end
            SAR_DEV_CONV: begin
                if (conv_fall && sel_low) begin
                    // start during conversion aborts it and clears output
                    // no result is kept: the held sample's conversion was cut short
                    st_next.result = RESULT_RST;
                    st_next.busy = 1'b0;
                    st_next.track = 1'b1;
                    st_next.st = SAR_DEV_TRACK;
                end else if (last_tick) begin
                    // fixed tick count keeps the period under the limit
                    st_next.result = st_reg.hold; // R2
                    st_next.busy = 1'b0; // R10
                    st_next.track = 1'b1; // R4
                    st_next.done = 1'b1;
                    st_next.st = SAR_DEV_TRACK;
                end else if (osc_tick) begin
                    st_next.tick_cnt = st_reg.tick_cnt + 8'h01; // R1
                end
            end
            default: begin
                st_next.st = SAR_DEV_TRACK;
                st_next.busy = 1'b0;
                st_next.track = 1'b1;
            end
        endcase

        // ******************************
        // readout
        // ******************************
        // enable follows synced select and strobe
        // three edges after the pins: two sync flops and this register
        st_next.oe = sel_low & ~st_reg.rd_s[1]; // R11
        st_next.bus = fold_word(st_reg.result, st_reg.byte_s[1]); // R7 R12
    end

    // ******************************
    // registers
    // ******************************
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            st_reg.st <= SAR_DEV_TRACK;
            // sync flops at idle pin levels: no false start after reset
            st_reg.conv_s <= 2'b11;
            st_reg.cs_s <= 2'b11;
            st_reg.rd_s <= 2'b11;
            st_reg.byte_s <= 2'b00;
            st_reg.conv_prev <= 1'b1;
            st_reg.osc_cnt <= 8'h00;
            st_reg.tick_cnt <= 8'h00;
            st_reg.hold <= RESULT_RST;
            st_reg.result <= RESULT_RST;
            st_reg.busy <= 1'b0;
            st_reg.bus <= RESULT_RST;
            st_reg.oe <= 1'b0;
            st_reg.track <= 1'b1;
            st_reg.done <= 1'b0;
        end else begin
            st_reg <= st_next;
        end
    end

    // ******************************
    // outputs
    // ******************************
    assign link.busy = st_reg.busy;
    assign link.result_bus = st_reg.bus;
    assign link.result_oe = st_reg.oe; // R11
    assign tracking = st_reg.track;
    assign conv_done = st_reg.done;

endmodule : sar_dev
`default_nettype wire

// [rtl/sar_host.sv]
// Purpose: host end: starts conversions and fetches results
// Assumes: busy and bus come from the converter, synchronised here
// Notes: WIDE_BUS=0 reads two bytes on the upper lanes
`timescale 1ns/1ps
`default_nettype none
module sar_host #(
    parameter bit WIDE_BUS = 1'b1
) (
    input wire logic ref_clk,
    input wire logic reset,
    sar_link_if.host link,
    input wire logic start,
    output logic ready,
    output logic [sar_pkg::RESULT_W-1:0] result,
    output logic result_valid
);
    import sar_pkg::*;

    // ******************************
    // state
    // ******************************
    typedef struct packed {
        sar_host_state_e st;
        logic [1:0] busy_s;
        logic [15:0] bus_s0;
        logic [15:0] bus_s1;
        logic [7:0] cnt;
        logic [7:0] acq_cnt;
        logic second;
        logic conversion_start_n_n;
        logic cs_n;
        logic rd_n;
        logic byte_sel;
        logic [15:0] data;
        logic valid;
    } sar_host_s;

    sar_host_s st_reg;
    sar_host_s st_next;

    always_comb begin
        st_next = st_reg;
        st_next.valid = 1'b0;
        st_next.busy_s = {st_reg.busy_s[0], link.busy};
        // bus lines come from the far end: two flops before capture
        st_next.bus_s0 = link.result_wire;
        st_next.bus_s1 = st_reg.bus_s0;
        if (st_reg.acq_cnt != 8'h00) begin
            st_next.acq_cnt = st_reg.acq_cnt - 8'h01; // R5
        end

        case (st_reg.st)
            SAR_HOST_IDLE: begin
                if (start && st_reg.acq_cnt == 8'h00) begin // R5
                    st_next.conversion_start_n_n = 1'b0; // R9
                    st_next.cs_n = 1'b0; // R9
                    st_next.cnt = 8'h00;
                    st_next.st = SAR_HOST_START;
                end
            end
            SAR_HOST_START: begin
                st_next.cnt = st_reg.cnt + 8'h01;
                if (st_reg.cnt == CONVERSION_START_N_CYC - 8'h01) begin
                    st_next.conversion_start_n_n = 1'b1; // R9
                    st_next.cs_n = 1'b1;
                    st_next.st = SAR_HOST_WAIT_HI;
                end
            end
            SAR_HOST_WAIT_HI: begin
                if (st_reg.busy_s[1]) begin
                    st_next.st = SAR_HOST_WAIT_LO;
                end
            end
            SAR_HOST_WAIT_LO: begin
                // falling busy is the completion event
                if (!st_reg.busy_s[1]) begin // R8 R13
                    st_next.cs_n = 1'b0; // R6
                    st_next.rd_n = 1'b0; // R6
                    st_next.byte_sel = 1'b0; // R7
                    st_next.second = 1'b0;
                    st_next.cnt = 8'h00;
                    st_next.acq_cnt = ACQ_CYC;
                    st_next.st = SAR_HOST_READ;
                end
            end
            SAR_HOST_READ: begin
                st_next.cnt = st_reg.cnt + 8'h01;
                if (st_reg.cnt == RD_HOLD_CYC - 8'h01) begin
                    st_next.rd_n = 1'b1; // R6
                    st_next.cnt = 8'h00;
                    if (WIDE_BUS) begin
                        st_next.data = st_reg.bus_s1;
                        st_next.cs_n = 1'b1;
                        st_next.valid = 1'b1;
                        st_next.st = SAR_HOST_IDLE;
                    end else if (!st_reg.second) begin
                        st_next.data[15:8] = st_reg.bus_s1[15:8];
                        st_next.byte_sel = 1'b1;
                        st_next.second = 1'b1;
                        st_next.st = SAR_HOST_GAP;
                    end else begin
                        st_next.data[7:0] = st_reg.bus_s1[15:8];
                        st_next.byte_sel = 1'b0;
                        st_next.cs_n = 1'b1;
                        st_next.valid = 1'b1;
                        st_next.st = SAR_HOST_IDLE;
                    end
                end
            end
            SAR_HOST_GAP: begin
                // strobe high long enough for byte select to settle
                st_next.cnt = st_reg.cnt + 8'h01;
                if (st_reg.cnt == RD_HOLD_CYC - 8'h01) begin
                    st_next.rd_n = 1'b0; // R6
                    st_next.cnt = 8'h00;
                    st_next.st = SAR_HOST_READ;
                end
            end
            default: begin
                st_next.st = SAR_HOST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            st_reg.st <= SAR_HOST_IDLE;
            st_reg.busy_s <= 2'b00;
            st_reg.bus_s0 <= RESULT_RST;
            st_reg.bus_s1 <= RESULT_RST;
            st_reg.cnt <= 8'h00;
            st_reg.acq_cnt <= 8'h00;
            st_reg.second <= 1'b0;
            st_reg.conversion_start_n_n <= 1'b1;
            st_reg.cs_n <= 1'b1;
            st_reg.rd_n <= 1'b1;
            st_reg.byte_sel <= 1'b0;
            st_reg.data <= RESULT_RST;
            st_reg.valid <= 1'b0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign link.conversion_start_n = st_reg.conversion_start_n_n;
    assign link.cs_n = st_reg.cs_n;
    assign link.rd_n = st_reg.rd_n;
    assign link.byte_sel = st_reg.byte_sel;
    assign ready = (st_reg.st == SAR_HOST_IDLE) && (st_reg.acq_cnt == 8'h00);
    assign result = st_reg.data;
    assign result_valid = st_reg.valid;

endmodule : sar_host
`default_nettype wire

// [rtl/sar_link_if.sv]
// Purpose: pins between converter and host
// Assumes: one clock for both ends
// Notes: the result bus is three-state; level resolved here
`timescale 1ns/1ps
`default_nettype none
interface sar_link_if;
    logic conversion_start_n;
    logic cs_n;
    logic rd_n;
    logic byte_sel;
    logic busy;
    logic [15:0] result_bus;
    logic result_oe;
    wire [15:0] result_wire;

    // no keeper on the lines: a released bus shows the inverse, so an early sample reads wrong
    assign result_wire = result_oe ? result_bus : ~result_bus;

    modport dev (
        input conversion_start_n,
        input cs_n,
        input rd_n,
        input byte_sel,
        output busy,
        output result_bus,
        output result_oe
    );

    modport host (
        output conversion_start_n,
        output cs_n,
        output rd_n,
        output byte_sel,
        input busy,
        input result_wire
    );
endinterface : sar_link_if
`default_nettype wire

// [rtl/sar_pkg.sv]
// Purpose: shared constants and types for the converter link
// Assumes: ref_clk at 250 MHz
// Notes: cycle counts derive from times in ns, except OSC_DIV and RD_HOLD_CYC, which are set directly
package sar_pkg;

    // ******************************
    // clock and data widths
    // ******************************
    localparam int CLK_MHZ = 250;
    localparam int RESULT_W = 16;

    // ******************************
    // times as printed, in ns
    // ******************************
    localparam int CONV_TIME_NS = 650;
    localparam int ACQ_TIME_NS = 320;
    localparam int CONVERSION_START_N_MIN_NS = 20;

    // ******************************
    // derived cycle counts
    // ******************************
    // longest time rounds down
    localparam logic [7:0] CONV_CYC = 8'((CONV_TIME_NS * CLK_MHZ) / 1000);
    // least times round up
    localparam logic [7:0] ACQ_CYC = 8'((ACQ_TIME_NS * CLK_MHZ + 999) / 1000);
    localparam logic [7:0] CONVERSION_START_N_CYC = 8'((CONVERSION_START_N_MIN_NS * CLK_MHZ + 999) / 1000);
    // internal conversion clock: one enable pulse every OSC_DIV cycles
    localparam logic [7:0] OSC_DIV = 8'h02;
    localparam logic [7:0] CONV_TICKS = 8'(CONV_CYC / OSC_DIV);
    // strobe low time; covers the far end's two-flop input delay
    localparam logic [7:0] RD_HOLD_CYC = 8'h06;

    // ******************************
    // host memory map
    // ******************************
    localparam logic [31:0] ADC_READ_ADDR = 32'ha000c000;

    // ******************************
    // reset and fill values
    // ******************************
    localparam logic [15:0] RESULT_RST = 16'h0000;
    localparam logic [7:0] BYTE_FILL = 8'hff;

    typedef enum logic [1:0] {
        SAR_DEV_TRACK = 2'b00,
        SAR_DEV_CONV = 2'b01
    } sar_dev_state_e;

    typedef enum logic [2:0] {
        SAR_HOST_IDLE = 3'b000,
        SAR_HOST_START = 3'b001,
        SAR_HOST_WAIT_HI = 3'b010,
        SAR_HOST_WAIT_LO = 3'b011,
        SAR_HOST_READ = 3'b100,
        SAR_HOST_GAP = 3'b101
    } sar_host_state_e;

endpackage : sar_pkg

// [tb/sar_link_assertions.sv]
// Purpose: protocol checks on the link between converter and host
// Assumes: one clock, reset async active high
// Notes: sees the first link only; both ends there are design code
`timescale 1ns/1ps
`default_nettype none
module sar_link_assertions (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic conversion_start_n,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic byte_sel,
    input wire logic busy,
    input wire logic [15:0] result_bus,
    input wire logic result_oe
);
    import sar_pkg::*;
    // ****************
    // helper counters
    // ****************
    logic [7:0] busy_reg;
    // saturates, so the first start after reset sees a long gap
    logic [7:0] idle_reg;
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            busy_reg <= 8'h00;
            idle_reg <= 8'hff;
        end else begin
            busy_reg <= busy ? busy_reg + 8'h01 : 8'h00;
            idle_reg <= busy ? 8'h00 : (idle_reg == 8'hff ? idle_reg : idle_reg + 8'h01);
        end
    end
    // ****************
    // properties
    // ****************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    sequence s_start;
        $fell(conversion_start_n) && !cs_n;
    endsequence
    sequence s_read;
        $fell(rd_n);
    endsequence
    a_start_busy: assert property (s_start ##0 !busy |-> ##[1:5] busy)
        else $error("busy missing after start");
    a_busy_length: assert property ($fell(busy) |->
        busy_reg > (CONV_TICKS - 8'h01) * OSC_DIV && busy_reg <= CONV_CYC)
        else $error("conversion length off");
    a_start_width: assert property (s_start |-> (!conversion_start_n && !cs_n)[*5])
        else $error("start pulse too short");
    a_acq_gap: assert property (s_start |-> idle_reg >= ACQ_CYC)
        else $error("acquisition gap too short");
    a_bus_driven: assert property ((!cs_n && !rd_n)[*5] |-> result_oe)
        else $error("bus not driven during read");
    a_bus_released: assert property ((cs_n || rd_n)[*4] |-> !result_oe)
        else $error("bus driven outside read");
    a_wide_word: assert property (!byte_sel)
        else $error("byte fold used on wide bus");
    a_read_idle: assert property (s_read |-> !busy)
        else $error("read during conversion");
    a_read_follows: assert property ($fell(busy) |-> ##[1:8] $fell(rd_n))
        else $error("no read after conversion");
    a_strobe_once: assert property (s_read |-> (!rd_n && !cs_n)[*5] ##[1:3] rd_n)
        else $error("read strobe malformed");
    a_read_stable: assert property (result_oe && $past(result_oe) |-> $stable(result_bus))
        else $error("bus word changed during read");
endmodule : sar_link_assertions
`default_nettype wire

// [tb/tb.sv]
// Purpose: self-checking bench for converter and host ends
// Assumes: ref_clk 250 MHz, reset async active high
// Notes: a second converter is driven by the bench for folding and abort
`timescale 1ns/1ps
`default_nettype none
module tb;
    import sar_pkg::*;
    logic ref_clk;
    logic reset;
    logic start, ready, result_valid, tracking, conv_done, tracking_b, done_b;
    logic [15:0] result, analog_in, analog_b;
    logic start_c, ready_c, valid_c;
    logic [15:0] result_c, analog_c;
    int n_fail = 0;
    int check_count = 0;
    sar_link_if link();
    sar_link_if link_b();
    sar_link_if link_c();
    sar_dev u_sar_dev (.ref_clk(ref_clk), .reset(reset), .link(link), .analog_in(analog_in),
        .tracking(tracking), .conv_done(conv_done));
    sar_host #(.WIDE_BUS(1'b1)) u_sar_host (.ref_clk(ref_clk), .reset(reset), .link(link),
        .start(start), .ready(ready), .result(result), .result_valid(result_valid));
    sar_dev u_sar_dev_b (.ref_clk(ref_clk), .reset(reset), .link(link_b),
        .analog_in(analog_b), .tracking(tracking_b), .conv_done(done_b));
    // third pair: host on the folded 8-bit bus
    sar_dev u_sar_dev_c (.ref_clk(ref_clk), .reset(reset), .link(link_c), .analog_in(analog_c),
        .tracking(), .conv_done());
    sar_host #(.WIDE_BUS(1'b0)) u_sar_host_c (.ref_clk(ref_clk), .reset(reset), .link(link_c),
        .start(start_c), .ready(ready_c), .result(result_c), .result_valid(valid_c));
    sar_link_assertions u_sar_link_assertions (.ref_clk(ref_clk), .reset(reset),
        .conversion_start_n(link.conversion_start_n), .cs_n(link.cs_n), .rd_n(link.rd_n),
        .byte_sel(link.byte_sel), .busy(link.busy), .result_bus(link.result_bus),
        .result_oe(link.result_oe));
    // ****************
    // helpers
    // ****************
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : step
    task automatic check16(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            n_fail++;
        end
    endtask : check16
    task automatic check1(input logic got, input logic exp);
        check16({15'h0000, got}, {15'h0000, exp});
    endtask : check1
    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : give_verdict
    task automatic b_pins(input logic cv, input logic cs, input logic rd, input logic bs);
        link_b.conversion_start_n = cv;
        link_b.cs_n = cs;
        link_b.rd_n = rd;
        link_b.byte_sel = bs;
    endtask : b_pins
    // ****************
    // scenarios
    // ****************
    task automatic t_single(input logic [15:0] val);
        analog_in = val;
        start = 1'b1;
        // start stays up while refused; only the ready edge takes it
        for (int i = 0; i < 200 && ready !== 1'b1; i++) step(1);
        step(1);
        start = 1'b0;
        for (int i = 0; i < 10 && link.busy !== 1'b1; i++) step(1);
        check1(tracking, 1'b0);
        analog_in = ~val;
        for (int i = 0; i < 400 && link.busy !== 1'b0; i++) step(1);
        check1(conv_done, 1'b1);
        for (int i = 0; i < 400 && result_valid !== 1'b1; i++) step(1);
        check1(result_valid, 1'b1);
        check16(result, val);
        check1(tracking, 1'b1);
        $display("test single %h done", val);
    endtask : t_single
    task automatic b_read(input logic bs, input logic [15:0] exp);
        b_pins(1'b1, 1'b0, 1'b0, bs);
        step(5);
        check1(link_b.result_oe, 1'b1);
        check16(link_b.result_wire, exp);
        b_pins(1'b1, 1'b1, 1'b1, bs);
        step(5);
        check1(link_b.result_oe, 1'b0);
    endtask : b_read
    task automatic t_fold();
        logic [15:0] v;
        int n;
        v = 16'h3c5a;
        n = 0;
        analog_b = v;
        b_pins(1'b0, 1'b0, 1'b1, 1'b0);
        for (int i = 0; i < 300; i++) begin
            if (i == 5) b_pins(1'b1, 1'b1, 1'b1, 1'b0);
            step(1);
            if (link_b.busy === 1'b1) n++;
            else if (n > 0) break;
        end
        check1(done_b, 1'b1);
        check1(n > (int'(CONV_TICKS) - 1) * int'(OSC_DIV) && n <= int'(CONV_CYC), 1'b1);
        b_read(1'b0, v);
        b_read(1'b1, {v[7:0], BYTE_FILL});
        b_pins(1'b1, 1'b1, 1'b0, 1'b0);
        step(5);
        check1(link_b.result_oe, 1'b0);
        $display("test fold done");
    endtask : t_fold
    task automatic t_ignore();
        b_pins(1'b0, 1'b1, 1'b1, 1'b0);
        step(6);
        b_pins(1'b1, 1'b1, 1'b1, 1'b0);
        step(4);
        check1(link_b.busy, 1'b0);
        $display("test ignore done");
    endtask : t_ignore
    task automatic t_abort();
        logic bad;
        bad = 1'b0;
        step(80);
        b_pins(1'b0, 1'b0, 1'b1, 1'b0);
        step(5);
        b_pins(1'b1, 1'b0, 1'b1, 1'b0);
        step(30);
        check1(link_b.busy, 1'b1);
        b_pins(1'b0, 1'b0, 1'b1, 1'b0);
        step(5);
        b_pins(1'b1, 1'b1, 1'b1, 1'b0);
        for (int i = 0; i < 170; i++) begin
            step(1);
            bad = bad | done_b | link_b.busy;
        end
        check1(bad, 1'b0);
        check1(tracking_b, 1'b1);
        b_read(1'b0, RESULT_RST);
        $display("test abort done");
    endtask : t_abort
    task automatic t_narrow(input logic [15:0] val);
        analog_c = val;
        start_c = 1'b1;
        for (int i = 0; i < 200 && ready_c !== 1'b1; i++) step(1);
        step(1);
        start_c = 1'b0;
        for (int i = 0; i < 400 && valid_c !== 1'b1; i++) step(1);
        check1(valid_c, 1'b1);
        check16(result_c, val);
        $display("test narrow %h done", val);
    endtask : t_narrow
    // ****************
    // main sequence
    // ****************
    initial begin
        reset = 1'b1;
        start = 1'b0;
        analog_in = 16'h0000;
        analog_b = 16'h0000;
        start_c = 1'b0;
        analog_c = 16'h0000;
        b_pins(1'b1, 1'b1, 1'b1, 1'b0);
        step(2);
        reset = 1'b0;
        t_single(16'ha5c3);
        check1(ready, 1'b0);
        t_single(16'hffff);
        t_single(16'h0000);
        t_narrow(16'h9d27);
        t_fold();
        t_ignore();
        t_abort();
        give_verdict();
    end
    initial begin
        #20000;
        n_fail++;
        give_verdict();
    end
endmodule : tb
`default_nettype wire
